/* File: shared/pwc_consts.vh */
`ifndef PWC_CONSTS_VH
`define PWC_CONSTS_VH

// ****************************************
// Sample and record geometry
// ****************************************
`define PWC_SMP_W 16
`define PWC_WORD_W 96
`define PWC_REC_LEN 11'h400
`define PWC_REC_AW 10
`define PWC_SLOT_W 4
`define PWC_SLOT_LAST 4'h9
`define PWC_SLOTS 4'ha
`define PWC_MEM_DEPTH 10240

// ****************************************
// Density codes and cycle counts
// ****************************************
`define PWC_SPC_128 2'h0
`define PWC_SPC_64 2'h1
`define PWC_SPC_32 2'h2
`define PWC_SPC_16 2'h3
`define PWC_SPC_MAX_LOG2 3'h7
`define PWC_TOT_MIN 7'h08
`define PWC_PRE_MIN 7'h01

// ****************************************
// Reset values
// ****************************************
`define PWC_RST_SPC 2'h0
`define PWC_RST_PRE 7'h04
`define PWC_RST_POST 7'h04

// ****************************************
// Timing
// ****************************************
`define PWC_CLK_HZ 50000000
`define PWC_HOLD_S 3
// Quiet time of PWC_HOLD_S seconds at PWC_CLK_HZ, sized to the counter width.
`define PWC_HOLD_CYC 28'd150000000
`define PWC_HOLD_CW 28

`endif

/* File: design/pwc_holdoff.v */
`timescale 1ns/1ns
`include "pwc_consts.vh"

module pwc_holdoff #(
  parameter [`PWC_HOLD_CW-1:0] HOLD_CYC = `PWC_HOLD_CYC
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_b_i,
  // Start of a new quiet interval.
  input wire start_i,
  // High while the quiet interval runs.
  output reg busy_o
);

  reg [`PWC_HOLD_CW-1:0] cnt;

  // Busy stays high for exactly HOLD_CYC cycles after the start pulse.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= {`PWC_HOLD_CW{1'b0}};
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt <= HOLD_CYC;
      busy_o <= 1'b1;
    end else if (cnt != {`PWC_HOLD_CW{1'b0}}) begin
      cnt <= cnt - 1'b1;
      busy_o <= (cnt != {{(`PWC_HOLD_CW-1){1'b0}}, 1'b1});
    end
  end

endmodule

/* File: design/pwc_capture.v */
// Behaviour
// (RULE1) With capture disabled, no record starts, neither by trigger nor otherwise.
// (RULE2) Density selects 128, 64, 32 or 16 samples per line cycle.
// (RULE3) Record length is 8, 16, 32 or 64 cycles for those densities.
// (RULE4) Pre-trigger cycles run 1 to total; pre plus post equals total.
// (RULE5) Post-trigger cycles are derived as total minus pre, never set separately.
// (RULE6) A record holds the pre-trigger cycles followed by the post-trigger cycles.
// (RULE7) Software should preferably program equal pre and post cycle counts.
// (RULE8) While armed, pre-trigger history is kept in a continuously overwritten ring.
// (RULE9) Each record holds three phase voltages and three phase currents together.
// (RULE10) No new event-triggered record within 3 s of the previous event.
// (RULE11) At most ten records kept; a new one replaces the oldest.
`timescale 1ns/1ns
`include "pwc_consts.vh"

module pwc_capture #(
  parameter [`PWC_HOLD_CW-1:0] HOLD_CYC = `PWC_HOLD_CYC
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_b_i,
  // Configuration.
  input wire cap_en_i,
  input wire [1:0] spc_sel_i,
  input wire [6:0] pre_cyc_i,
  // Triggers.
  input wire event_trig_i,
  input wire manual_trig_i,
  // Sample stream.
  input wire smp_valid_i,
  input wire [`PWC_SMP_W-1:0] va_i,
  input wire [`PWC_SMP_W-1:0] vb_i,
  input wire [`PWC_SMP_W-1:0] vc_i,
  input wire [`PWC_SMP_W-1:0] ia_i,
  input wire [`PWC_SMP_W-1:0] ib_i,
  input wire [`PWC_SMP_W-1:0] ic_i,
  // Readout request.
  input wire rd_en_i,
  input wire [`PWC_SLOT_W-1:0] rd_slot_i,
  input wire [`PWC_REC_AW-1:0] rd_idx_i,
  // Readout data.
  output reg rd_valid_o,
  output reg [`PWC_SMP_W-1:0] rd_va_o,
  output reg [`PWC_SMP_W-1:0] rd_vb_o,
  output reg [`PWC_SMP_W-1:0] rd_vc_o,
  output reg [`PWC_SMP_W-1:0] rd_ia_o,
  output reg [`PWC_SMP_W-1:0] rd_ib_o,
  output reg [`PWC_SMP_W-1:0] rd_ic_o,
  // Status.
  output reg armed_o,
  output reg capturing_o,
  output reg rec_done_o,
  output reg [`PWC_SLOT_W-1:0] rec_count_o,
  output reg [`PWC_SLOT_W-1:0] newest_slot_o,
  output reg [6:0] pre_used_o,
  output reg [6:0] post_cyc_o,
  output wire holdoff_o
);

  // ****************************************
  // States and decoding helpers
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARM = 3'b010;
  localparam [2:0] ST_POST = 3'b100;

  // Total record length in cycles for a density code.
  function [6:0] tot_cyc;
    input [1:0] code;
    begin
      tot_cyc = `PWC_TOT_MIN << code; // RULE3
    end
  endfunction

  // Converts a cycle count to samples at a density code.
  function [10:0] cyc2smp;
    input [6:0] n;
    input [1:0] code;
    begin
      cyc2smp = {4'h0, n} << (`PWC_SPC_MAX_LOG2 - {1'b0, code}); // RULE2
    end
  endfunction

  // Clamps the requested pre-trigger count into 1..total.
  function [6:0] pre_fit;
    input [6:0] n;
    input [1:0] code;
    begin
      if (n < `PWC_PRE_MIN) begin
        pre_fit = `PWC_PRE_MIN; // RULE4
      end else if (n > tot_cyc(code)) begin
        pre_fit = tot_cyc(code); // RULE4
      end else begin
        pre_fit = n;
      end
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg [`PWC_WORD_W-1:0] mem [0:`PWC_MEM_DEPTH-1];
  reg [`PWC_REC_AW-1:0] start_ofs [0:`PWC_SLOTS-1];

  reg [2:0] state;
  reg [1:0] spc;
  reg [`PWC_REC_AW-1:0] wp;
  reg [10:0] fill;
  reg [10:0] post_left;
  reg [`PWC_SLOT_W-1:0] wslot;
  wire hold_busy;

  // ****************************************
  // Datapath terms
  // ****************************************
  wire st_arm = (state == ST_ARM);
  wire st_post = (state == ST_POST);
  wire wr = smp_valid_i & (st_arm | st_post);
  wire [`PWC_REC_AW-1:0] wp_n = wp + {{(`PWC_REC_AW-1){1'b0}}, wr};
  wire [10:0] fill_n = (fill == `PWC_REC_LEN) ? fill : fill + {10'h0, wr};
  wire [10:0] pre_smp = cyc2smp(pre_used_o, spc);
  wire [10:0] post_smp = `PWC_REC_LEN - pre_smp;
  wire ev_ok = event_trig_i & ~hold_busy; // RULE10
  // A trigger counts only once the ring holds the full pre-trigger span.
  wire accept = st_arm & cap_en_i & (fill_n >= pre_smp) & (manual_trig_i | ev_ok); // RULE6
  wire last_post = st_post & cap_en_i & wr & (post_left == 11'h001);
  wire finish = (accept & (post_smp == 11'h000)) | last_post;
  wire [`PWC_WORD_W-1:0] word = {va_i, vb_i, vc_i, ia_i, ib_i, ic_i}; // RULE9
  wire rd_ok = rd_en_i & (rd_slot_i <= `PWC_SLOT_LAST);
  wire [`PWC_REC_AW-1:0] rd_ofs = start_ofs[rd_slot_i] + rd_idx_i;

  // Quiet interval started when each event trigger is accepted.
  pwc_holdoff #(
    .HOLD_CYC(HOLD_CYC)
  ) u_hold (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(accept & ev_ok), // RULE10
    .busy_o(hold_busy)
  );

  assign holdoff_o = hold_busy;

  // ****************************************
  // Sample memory
  // ****************************************
  // The ring for the slot in use is overwritten while armed, so history is
  // always the newest samples. Limitation: arming already reuses the oldest slot.
  always @(posedge clk_i) begin
    if (wr) begin
      mem[{wslot, wp}] <= word; // RULE8
    end
    if (finish) begin
      start_ofs[wslot] <= wp_n; // RULE6
    end
  end

  // ****************************************
  // Capture control
  // ****************************************
  // Configuration is latched on arming so a record never mixes densities.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      spc <= `PWC_RST_SPC;
      pre_used_o <= `PWC_RST_PRE;
      post_cyc_o <= `PWC_RST_POST;
      wp <= {`PWC_REC_AW{1'b0}};
      fill <= 11'h000;
      post_left <= 11'h000;
      armed_o <= 1'b0;
      capturing_o <= 1'b0;
    end else begin
      wp <= wp_n;
      fill <= fill_n;
      case (state)
        ST_IDLE: begin
          wp <= {`PWC_REC_AW{1'b0}};
          fill <= 11'h000;
          capturing_o <= 1'b0;
          if (cap_en_i) begin // RULE1
            spc <= spc_sel_i;
            pre_used_o <= pre_fit(pre_cyc_i, spc_sel_i);
            post_cyc_o <= tot_cyc(spc_sel_i) - pre_fit(pre_cyc_i, spc_sel_i); // RULE5
            state <= ST_ARM;
            armed_o <= 1'b1;
          end
        end
        ST_ARM: begin
          if (!cap_en_i) begin
            state <= ST_IDLE; // RULE1
            armed_o <= 1'b0;
          end else if (finish) begin
            state <= ST_IDLE;
            armed_o <= 1'b0;
          end else if (accept) begin
            state <= ST_POST;
            post_left <= post_smp; // RULE5
            armed_o <= 1'b0;
            capturing_o <= 1'b1;
          end
        end
        ST_POST: begin
          if (!cap_en_i || last_post) begin
            state <= ST_IDLE; // RULE1
            capturing_o <= 1'b0;
          end else if (wr) begin
            post_left <= post_left - 11'h001; // RULE6
          end
        end
        default: begin
          state <= ST_IDLE;
          armed_o <= 1'b0;
          capturing_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Record slots
  // ****************************************
  // Slots are used round robin, so once all ten hold records the next slot is the oldest one.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wslot <= {`PWC_SLOT_W{1'b0}};
      rec_count_o <= {`PWC_SLOT_W{1'b0}};
      newest_slot_o <= {`PWC_SLOT_W{1'b0}};
      rec_done_o <= 1'b0;
    end else begin
      rec_done_o <= finish;
      if (finish) begin
        newest_slot_o <= wslot;
        if (rec_count_o != `PWC_SLOTS) begin
          rec_count_o <= rec_count_o + 1'b1; // RULE11
        end
        if (wslot == `PWC_SLOT_LAST) begin
          wslot <= {`PWC_SLOT_W{1'b0}}; // RULE11
        end else begin
          wslot <= wslot + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Readout
  // ****************************************
  // Index 0 is the oldest sample of the record, whatever the ring position.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_valid_o <= 1'b0;
      rd_va_o <= {`PWC_SMP_W{1'b0}};
      rd_vb_o <= {`PWC_SMP_W{1'b0}};
      rd_vc_o <= {`PWC_SMP_W{1'b0}};
      rd_ia_o <= {`PWC_SMP_W{1'b0}};
      rd_ib_o <= {`PWC_SMP_W{1'b0}};
      rd_ic_o <= {`PWC_SMP_W{1'b0}};
    end else begin
      rd_valid_o <= rd_ok;
      if (rd_ok) begin
        {rd_va_o, rd_vb_o, rd_vc_o, rd_ia_o, rd_ib_o, rd_ic_o} <= mem[{rd_slot_i, rd_ofs}];
      end
    end
  end

endmodule

/* File: bench/pwc_src.sv */
`timescale 1ns/1ns
module pwc_src (
  // Clock and reset.
  input wire clk_i,
  input wire rst_b_i,
  // Pacing: high gives a sample every other cycle.
  input wire slow_i,
  // Sample stream.
  output reg smp_valid_o,
  output wire [15:0] va_o,
  output wire [15:0] vb_o,
  output wire [15:0] vc_o,
  output wire [15:0] ia_o,
  output wire [15:0] ib_o,
  output wire [15:0] ic_o
);
  reg [15:0] cnt;
  reg ph;
  // Between samples the lines carry the inverted count, so stale data never looks right.
  wire [15:0] b = smp_valid_o ? cnt : ~cnt;
  assign va_o = b;
  assign vb_o = b + 16'h1;
  assign vc_o = b + 16'h2;
  assign ia_o = b + 16'h3;
  assign ib_o = b + 16'h4;
  assign ic_o = b + 16'h5;
  // The count advances once per delivered sample.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 16'h0;
      ph <= 1'b0;
      smp_valid_o <= 1'b0;
    end else begin
      ph <= ~ph;
      smp_valid_o <= !slow_i | ph;
      if (smp_valid_o) cnt <= cnt + 16'h1;
    end
  end
endmodule

/* File: bench/pwc_chk.sv */
`timescale 1ns/1ns
module pwc_chk (
  // Clock and reset.
  input wire clk_i,
  input wire rst_b_i,
  // Inputs.
  input wire cap_en_i,
  input wire event_trig_i,
  input wire manual_trig_i,
  input wire rd_en_i,
  input wire [3:0] rd_slot_i,
  // Outputs.
  input wire rd_valid_o,
  input wire armed_o,
  input wire capturing_o,
  input wire rec_done_o,
  input wire [3:0] rec_count_o,
  input wire [6:0] pre_used_o,
  input wire [6:0] post_cyc_o,
  input wire holdoff_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire rd_ok = rd_en_i && (rd_slot_i <= 4'h9);
  wire [7:0] sum = {1'b0, pre_used_o} + {1'b0, post_cyc_o};
  property p_off; !cap_en_i |=> !armed_o && !capturing_o; endproperty
  a_off: assert property (p_off) else $error("active while disabled");
  property p_sum; pre_used_o != 7'h0 && sum inside {8'h08, 8'h10, 8'h20, 8'h40}; endproperty
  a_sum: assert property (p_sum) else $error("bad cycle split");
  property p_rise; $rose(capturing_o) |-> $past(armed_o); endproperty
  a_rise: assert property (p_rise) else $error("capture without arming");
  property p_hold;
    armed_o && holdoff_o && event_trig_i && !manual_trig_i |=> !capturing_o && !rec_done_o;
  endproperty
  a_hold: assert property (p_hold) else $error("trigger taken in quiet time");
  property p_rd; rd_ok |=> rd_valid_o; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rdx; !rd_ok |=> !rd_valid_o; endproperty
  a_rdx: assert property (p_rdx) else $error("spurious read valid");
  property p_cnt;
    rec_done_o |-> rec_count_o == (($past(rec_count_o) == 4'ha) ? 4'ha : $past(rec_count_o) + 4'h1);
  endproperty
  a_cnt: assert property (p_cnt) else $error("record count wrong");
  property p_rearm; rec_done_o && cap_en_i |=> armed_o; endproperty
  a_rearm: assert property (p_rearm) else $error("no re-arm");
  property p_pulse; rec_done_o |=> !rec_done_o; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  c_done: cover property (rec_done_o);
  c_hold: cover property (armed_o && holdoff_o && event_trig_i);
  c_rd: cover property (rd_valid_o);
endmodule
bind pwc_capture pwc_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cap_en_i(cap_en_i),
  .event_trig_i(event_trig_i), .manual_trig_i(manual_trig_i), .rd_en_i(rd_en_i),
  .rd_slot_i(rd_slot_i), .rd_valid_o(rd_valid_o), .armed_o(armed_o),
  .capturing_o(capturing_o), .rec_done_o(rec_done_o), .rec_count_o(rec_count_o),
  .pre_used_o(pre_used_o), .post_cyc_o(post_cyc_o), .holdoff_o(holdoff_o));

/* File: bench/pwc_capture_bench.sv */
`timescale 1ns/1ns
module pwc_capture_bench;
  // ********
  // Stimulus and wiring.
  // ********
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg en = 1'b0, et = 1'b0, mt = 1'b0, rd = 1'b0, slow = 1'b0;
  reg [1:0] spc = 2'h0;
  reg [6:0] pre = 7'h0, tot;
  reg [3:0] slot = 4'h0;
  reg [9:0] idx = 10'h0;
  reg [15:0] t;
  wire sv, rv, arm, capt, done, hold;
  wire [15:0] va, vb, vc, ia, ib, ic, ra, rb, rc, qa, qb, qc;
  wire [3:0] cnt, nslot;
  wire [6:0] pu, pc;
  integer miscompares = 0, n_tests = 0, i, k;
  always #10 clk = ~clk;
  // The quiet time is cut to 3000 cycles so it still outlasts one ring fill.
  pwc_capture #(.HOLD_CYC(28'd3000)) dut_u (.clk_i(clk), .rst_b_i(rst_b), .cap_en_i(en),
    .spc_sel_i(spc), .pre_cyc_i(pre), .event_trig_i(et), .manual_trig_i(mt),
    .smp_valid_i(sv), .va_i(va), .vb_i(vb), .vc_i(vc), .ia_i(ia), .ib_i(ib), .ic_i(ic),
    .rd_en_i(rd), .rd_slot_i(slot), .rd_idx_i(idx), .rd_valid_o(rv), .rd_va_o(ra),
    .rd_vb_o(rb), .rd_vc_o(rc), .rd_ia_o(qa), .rd_ib_o(qb), .rd_ic_o(qc), .armed_o(arm),
    .capturing_o(capt), .rec_done_o(done), .rec_count_o(cnt), .newest_slot_o(nslot),
    .pre_used_o(pu), .post_cyc_o(pc), .holdoff_o(hold));
  pwc_src src_u (.clk_i(clk), .rst_b_i(rst_b), .slow_i(slow), .smp_valid_o(sv),
    .va_o(va), .vb_o(vb), .vc_o(vc), .ia_o(ia), .ib_o(ib), .ic_o(ic));
  // ********
  // Shared tasks.
  // ********
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("mismatch %0s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // The sample seen with the trigger is remembered as the last pre-trigger sample.
  // Between samples the lines show the inverted next count, so the last one is one below it.
  task trig(input m);
    @(posedge clk);
    if (m) mt <= 1'b1;
    else et <= 1'b1;
    @(negedge clk);
    t = sv ? va : ~va - 16'h1;
    @(posedge clk);
    mt <= 1'b0;
    et <= 1'b0;
  endtask
  task waitdone;
    for (i = 0; i < 3000 && done !== 1'b1; i = i + 1) @(negedge clk);
    chk("done", 1, done);
  endtask
  task rdc(input [3:0] s, input [9:0] x, input [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    slot <= s;
    idx <= x;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rvalid", 1, rv);
    chk("va", e, ra);
    chk("vb", e + 16'h1, rb);
    chk("vc", e + 16'h2, rc);
    chk("ia", e + 16'h3, qa);
    chk("ib", e + 16'h4, qb);
    chk("ic", e + 16'h5, qc);
  endtask
  task final_report;
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog sized well above the roughly 15000 cycles the tests need.
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    final_report;
  end
  // ********
  // Test sequence.
  // ********
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("pre", 4, pu);
    chk("post", 4, pc);
    chk("count", 0, cnt);
    @(posedge clk);
    rd <= 1'b1;
    slot <= 4'ha;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rvalid", 0, rv);
    // Every density, with equal halves before and after the trigger.
    for (k = 0; k < 4; k = k + 1) begin
      tot = 7'h08 << k;
      @(posedge clk);
      spc <= k[1:0];
      pre <= tot >> 1;
      en <= 1'b1;
      cyc(600);
      trig(1);
      waitdone;
      chk("pre", tot >> 1, pu);
      chk("post", tot >> 1, pc);
      chk("count", k + 1, cnt);
      chk("slot", k, nslot);
      rdc(nslot, 10'd511, t);
      rdc(nslot, 10'd0, t - 16'd511);
      rdc(nslot, 10'd1023, t + 16'd512);
      @(posedge clk);
      en <= 1'b0;
    end
    trig(1);
    @(negedge clk);
    chk("armed", 0, arm);
    chk("capt", 0, capt);
    chk("count", 4, cnt);
    // Oversized pre count at slow pacing, then a trigger inside the quiet time.
    @(posedge clk);
    spc <= 2'h3;
    pre <= 7'h7f;
    en <= 1'b1;
    slow <= 1'b1;
    cyc(2100);
    trig(0);
    waitdone;
    chk("pre", 64, pu);
    chk("post", 0, pc);
    chk("hold", 1, hold);
    cyc(2100);
    trig(0);
    @(negedge clk);
    chk("done", 0, done);
    trig(1);
    waitdone;
    chk("count", 6, cnt);
    chk("slot", 5, nslot);
    rdc(nslot, 10'd1023, t);
    rdc(nslot, 10'd0, t - 16'd1023);
    // Five more fast records fill all ten slots and wrap onto the oldest one.
    @(posedge clk);
    slow <= 1'b0;
    for (k = 6; k < 11; k = k + 1) begin
      cyc(1100);
      trig(1);
      waitdone;
      chk("count", (k < 10) ? k + 1 : 10, cnt);
    end
    chk("slot", 0, nslot);
    chk("hold", 0, hold);
    rdc(4'h0, 10'd1023, t);
    // A zero pre count is raised to one cycle on the next arming.
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    spc <= 2'h0;
    pre <= 7'h00;
    en <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk("pre", 1, pu);
    chk("post", 7, pc);
    final_report;
  end
endmodule
